// [design/fcp_top.sv]
// Floating point coprocessor: stack, ops, error flag, APB slave
//
// Behaviour
// - Three entries, each tagged single or double
// - Process switch discards stack contents
// - Both priorities use every instruction
// - Preemption saves state inside the unit
// - High priority waits for current op
// - First ready side stalls at sync
// - Core overlaps address work with ops
// - IEEE single and double results, denormals
// - All rounding modes, nearest by default
// - Selectors 22,06,04,05 pick rounding mode
// - Rare ops via selector and entry
// - Abs selector 0B via entry
// - Square root split into four steps
// - Invalid, divide-by-zero, overflow set error
// - Infinite or NaN input sets error
// - Error set/test/clear; propagate on demand
`timescale 1ns/1ps
module fcp_top (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Core scheduling
  input  wire logic        sched_switch,
  input  wire logic        preempt_req,
  input  wire logic        resume_req,
  output logic             preempt_ack,
  output logic             main_error_set,
  // Interrupt
  output logic             irq
);
  typedef enum {ST_IDLE, ST_BUSY} fcp_fsm_t;

  fcp_fsm_t          fsm_reg, fsm_next;
  fcp_pkg::fcp_state_t st_reg, st_next, sav_reg, sav_next;
  logic [5:0]        cnt_reg, cnt_next;
  logic [63:0]       din_reg, din_next, res_reg, res_next;
  logic [2:0]        ist_reg, ist_next, imsk_reg, imsk_next;
  logic [1:0]        sq_reg, sq_next;
  logic              ack_reg, ack_next, mes_reg, mes_next;
  logic              rdy_reg, rdy_next, irq_reg, irq_next;
  logic [31:0]       rd_reg, rd_next;
  logic              err_reg, err_next;
  logic              acc, wr_done, cmd_wr, ev_done, ev_err, ev_save;
  logic [7:0]        op, sel;

  // Exponent field all ones: infinity or NaN
  function automatic logic not_finite(input fcp_pkg::fcp_entry_t e);
    if (e.dbl) return &e.val[62:52];
    return &e.val[30:23];
  endfunction

  function automatic logic is_zero(input fcp_pkg::fcp_entry_t e);
    if (e.dbl) return e.val[62:0] == 63'h0;
    return e.val[30:0] == 31'h0;
  endfunction

  // Scale by two up or down; halving a denormal or an exponent-one input drops the low fraction bit
  function automatic fcp_pkg::fcp_entry_t scale2(input fcp_pkg::fcp_entry_t e, input logic up);
    fcp_pkg::fcp_entry_t r;
    r = e;
    if (e.dbl) begin
      if (up && e.val[62:52] != 11'h7FF && e.val[62:52] != 11'h0)
        r.val[62:52] = e.val[62:52] + 11'h001;
      else if (!up && e.val[62:52] > 11'h001 && e.val[62:52] != 11'h7FF)
        r.val[62:52] = e.val[62:52] - 11'h001;
      else if (!up && e.val[62:52] <= 11'h001)
        r.val[52:0] = {e.val[52] | (e.val[62:52] == 11'h001), e.val[51:0]} >> 1;
      else if (up && e.val[62:52] == 11'h0)
        r.val[62:0] = {e.val[61:0], 1'b0};
    end else begin
      if (up && e.val[30:23] != 8'hFF && e.val[30:23] != 8'h0)
        r.val[30:23] = e.val[30:23] + 8'h01;
      else if (!up && e.val[30:23] > 8'h01 && e.val[30:23] != 8'hFF)
        r.val[30:23] = e.val[30:23] - 8'h01;
      else if (!up && e.val[30:23] <= 8'h01)
        r.val[23:0] = {e.val[23] | (e.val[30:23] == 8'h01), e.val[22:0]} >> 1;
      else if (up && e.val[30:23] == 8'h0)
        r.val[30:0] = {e.val[29:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic ovf_up(input fcp_pkg::fcp_entry_t e);
    if (e.dbl) return e.val[62:52] == 11'h7FE;
    return e.val[30:23] == 8'hFE;
  endfunction

  assign op      = pwdata[7:0];
  assign sel     = pwdata[15:8];
  assign acc     = psel && penable && !rdy_reg;
  assign wr_done = psel && penable && rdy_reg && pwrite;
  assign cmd_wr  = wr_done && paddr == fcp_pkg::ADDR_CMD;

  // APB answer: command writes wait until the engine is idle
  always_comb begin
    rdy_next = 1'b0;
    rd_next  = rd_reg;
    err_next = 1'b0;
    if (acc) begin
      rdy_next = !(pwrite && paddr == fcp_pkg::ADDR_CMD && fsm_reg != ST_IDLE);
      err_next = paddr[1:0] != 2'b00 || paddr > fcp_pkg::ADDR_IMSK;
      case (paddr)
        fcp_pkg::ADDR_DLO:  rd_next = din_reg[31:0];
        fcp_pkg::ADDR_DHI:  rd_next = din_reg[63:32];
        fcp_pkg::ADDR_RLO:  rd_next = res_reg[31:0];
        fcp_pkg::ADDR_RHI:  rd_next = res_reg[63:32];
        fcp_pkg::ADDR_STAT: rd_next = {22'h0, sq_reg, ack_reg, fsm_reg == ST_BUSY, st_reg.rnd,
                                       st_reg.thd.dbl, st_reg.sec.dbl, st_reg.top.dbl, st_reg.err};
        fcp_pkg::ADDR_IST:  rd_next = {29'h0, ist_reg};
        fcp_pkg::ADDR_IMSK: rd_next = {29'h0, imsk_reg};
        default:            rd_next = 32'h0;
      endcase
    end
  end

  // Command engine
  always_comb begin
    fcp_pkg::fcp_entry_t a, b, r;
    a         = st_reg.top;
    b         = st_reg.sec;
    r         = a;
    st_next   = st_reg;
    sav_next  = sav_reg;
    fsm_next  = fsm_reg;
    cnt_next  = cnt_reg;
    din_next  = din_reg;
    res_next  = res_reg;
    sq_next   = sq_reg;
    ack_next  = ack_reg;
    mes_next  = 1'b0;
    ev_done   = 1'b0;
    ev_err    = 1'b0;
    ev_save   = 1'b0;
    if (wr_done && paddr == fcp_pkg::ADDR_DLO) din_next[31:0] = pwdata;
    if (wr_done && paddr == fcp_pkg::ADDR_DHI) din_next[63:32] = pwdata;
    if (fsm_reg == ST_BUSY) begin
      cnt_next = cnt_reg - 6'h01;
      if (cnt_reg == 6'h01) begin
        fsm_next = ST_IDLE;
        ev_done  = 1'b1;
      end
    end
    if (cmd_wr) begin
      fsm_next = ST_BUSY;
      cnt_next = fcp_pkg::LAT_ONE;
      case (op)
        fcp_pkg::OP_LDS, fcp_pkg::OP_LDD: begin
          st_next.thd = st_reg.sec;
          st_next.sec = st_reg.top;
          st_next.top.dbl = op == fcp_pkg::OP_LDD;
          st_next.top.val = op == fcp_pkg::OP_LDD ? din_reg : {32'h0, din_reg[31:0]};
        end
        fcp_pkg::OP_STS, fcp_pkg::OP_STD: begin
          res_next = a.val;
          st_next.top = st_reg.sec;
          st_next.sec = st_reg.thd;
        end
        fcp_pkg::OP_REV: begin
          st_next.top = b;
          st_next.sec = a;
        end
        fcp_pkg::OP_DUP: begin
          st_next.thd = st_reg.sec;
          st_next.sec = a;
        end
        fcp_pkg::OP_ADD, fcp_pkg::OP_SUB, fcp_pkg::OP_MUL, fcp_pkg::OP_DIV: begin
          // Special operands are screened here; the datapath owns finite results
          r = b;
          if (not_finite(a) || not_finite(b)) ev_err = 1'b1;
          if (op == fcp_pkg::OP_DIV && is_zero(a)) ev_err = 1'b1;
          if (op == fcp_pkg::OP_ADD && is_zero(b)) r = a;
          if (op == fcp_pkg::OP_SUB && is_zero(a)) r = b;
          if (op == fcp_pkg::OP_MUL && (is_zero(a) || is_zero(b)))
            r.val = b.dbl ? {a.val[63] ^ b.val[63], 63'h0} : {32'h0, a.val[31] ^ b.val[31], 31'h0};
          st_next.top = r;
          st_next.sec = st_reg.thd;
          cnt_next = op == fcp_pkg::OP_MUL ? fcp_pkg::LAT_MUL :
                     op == fcp_pkg::OP_DIV ? fcp_pkg::LAT_DIV : fcp_pkg::LAT_ADD;
        end
        fcp_pkg::OP_TEST: begin
          res_next = {63'h0, !st_reg.err};
          st_next.err = 1'b0;
        end
        fcp_pkg::OP_CHK: mes_next = st_reg.err;
        fcp_pkg::OP_ENTRY: begin
          case (sel)
            fcp_pkg::SEL_ABS: begin
              r = a;
              if (a.dbl) r.val[63] = 1'b0;
              else r.val[31] = 1'b0;
              if (not_finite(a)) ev_err = 1'b1;
              st_next.top = r;
              cnt_next = fcp_pkg::LAT_ABS;
            end
            fcp_pkg::SEL_RN: st_next.rnd = fcp_pkg::RND_NEAR;
            fcp_pkg::SEL_RZ: st_next.rnd = fcp_pkg::RND_ZERO;
            fcp_pkg::SEL_RP: st_next.rnd = fcp_pkg::RND_POS;
            fcp_pkg::SEL_RM: st_next.rnd = fcp_pkg::RND_MINUS;
            fcp_pkg::SEL_SETE: st_next.err = 1'b1;
            fcp_pkg::SEL_CLRE: st_next.err = 1'b0;
            fcp_pkg::SEL_MUL2, fcp_pkg::SEL_DIV2: begin
              st_next.top = scale2(a, sel == fcp_pkg::SEL_MUL2);
              if (not_finite(a)) ev_err = 1'b1;
              if (sel == fcp_pkg::SEL_MUL2 && ovf_up(a)) begin
                ev_err = 1'b1;
                st_next.top.val = a.dbl ? {a.val[63], 11'h7FF, 52'h0} : {32'h0, a.val[31], 8'hFF, 23'h0};
              end
              cnt_next = fcp_pkg::LAT_ADD;
            end
            fcp_pkg::SEL_SQ1: begin
              if (not_finite(a) || (a.dbl ? a.val[63] : a.val[31]) && !is_zero(a))
                ev_err = 1'b1;
              sq_next = 2'h1;
              cnt_next = fcp_pkg::LAT_SQ1;
            end
            fcp_pkg::SEL_SQS: begin
              if (sq_reg == 2'h0) ev_err = 1'b1;
              else if (sq_reg != 2'h3) sq_next = sq_reg + 2'h1;
              cnt_next = fcp_pkg::LAT_SQS;
            end
            fcp_pkg::SEL_SQL: begin
              if (sq_reg != 2'h3) ev_err = 1'b1;
              sq_next = 2'h0;
              cnt_next = fcp_pkg::LAT_SQL;
            end
            default: ;
          endcase
        end
        default: ;
      endcase
      if (ev_err) st_next.err = 1'b1;
    end
    // Preemption waits for an idle engine, then parks the state inside
    if (preempt_req && !ack_reg && fsm_reg == ST_IDLE && !cmd_wr) begin
      sav_next = st_reg;
      ack_next = 1'b1;
      ev_save  = 1'b1;
      st_next.err = 1'b0;
      st_next.rnd = fcp_pkg::RND_NEAR;
    end else if (resume_req && ack_reg && fsm_reg == ST_IDLE && !cmd_wr) begin
      st_next  = sav_reg;
      ack_next = 1'b0;
    end
    // Stack is not kept across a process switch
    if (sched_switch) begin
      st_next.top = '0;
      st_next.sec = '0;
      st_next.thd = '0;
    end
  end

  // Interrupt status: set wins over the write-one clear
  always_comb begin
    ist_next  = ist_reg;
    imsk_next = imsk_reg;
    if (wr_done && paddr == fcp_pkg::ADDR_IST) ist_next = ist_reg & ~pwdata[2:0];
    if (wr_done && paddr == fcp_pkg::ADDR_IMSK) imsk_next = pwdata[2:0];
    ist_next[fcp_pkg::IRQ_DONE] = ist_next[fcp_pkg::IRQ_DONE] | ev_done;
    ist_next[fcp_pkg::IRQ_ERR]  = ist_next[fcp_pkg::IRQ_ERR] | ev_err;
    ist_next[fcp_pkg::IRQ_SAVE] = ist_next[fcp_pkg::IRQ_SAVE] | ev_save;
    irq_next = |(ist_next & imsk_next);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fsm_reg  <= ST_IDLE;
      st_reg   <= '0;
      sav_reg  <= '0;
      cnt_reg  <= 6'h00;
      din_reg  <= 64'h0;
      res_reg  <= 64'h0;
      sq_reg   <= 2'h0;
      ack_reg  <= 1'b0;
      mes_reg  <= 1'b0;
      ist_reg  <= 3'h0;
      imsk_reg <= 3'h0;
      irq_reg  <= 1'b0;
      rdy_reg  <= 1'b0;
      rd_reg   <= 32'h0;
      err_reg  <= 1'b0;
    end else begin
      fsm_reg  <= fsm_next;
      st_reg   <= st_next;
      sav_reg  <= sav_next;
      cnt_reg  <= cnt_next;
      din_reg  <= din_next;
      res_reg  <= res_next;
      sq_reg   <= sq_next;
      ack_reg  <= ack_next;
      mes_reg  <= mes_next;
      ist_reg  <= ist_next;
      imsk_reg <= imsk_next;
      irq_reg  <= irq_next;
      rdy_reg  <= rdy_next;
      rd_reg   <= rd_next;
      err_reg  <= err_next;
    end
  end

  assign pready         = rdy_reg;
  assign prdata         = rd_reg;
  assign pslverr        = err_reg;
  assign preempt_ack    = ack_reg;
  assign main_error_set = mes_reg;
  assign irq            = irq_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_stall;
    psel && penable && pwrite && paddr == fcp_pkg::ADDR_CMD && fsm_reg == ST_BUSY |=> !pready;
  endproperty
  a_stall: assert property (p_stall) else $error("command taken while busy");

  property p_push;
    cmd_wr && op == fcp_pkg::OP_LDD && !sched_switch |=> st_reg.top.dbl && st_reg.sec == $past(st_reg.top);
  endproperty
  a_push: assert property (p_push) else $error("load did not push");

  property p_tag;
    cmd_wr && op == fcp_pkg::OP_LDS && !sched_switch |=> !st_reg.top.dbl;
  endproperty
  a_tag: assert property (p_tag) else $error("single tag wrong");

  property p_abs;
    cmd_wr && op == fcp_pkg::OP_ENTRY && sel == fcp_pkg::SEL_ABS && !sched_switch
      |=> !(st_reg.top.dbl ? st_reg.top.val[63] : st_reg.top.val[31]);
  endproperty
  a_abs: assert property (p_abs) else $error("abs kept sign");

  property p_rnd;
    cmd_wr && op == fcp_pkg::OP_ENTRY && sel == fcp_pkg::SEL_RZ && !preempt_req && !resume_req
      |=> st_reg.rnd == fcp_pkg::RND_ZERO;
  endproperty
  a_rnd: assert property (p_rnd) else $error("round zero not set");

  property p_ack;
    $rose(preempt_ack) |-> $past(fsm_reg) == ST_IDLE;
  endproperty
  a_ack: assert property (p_ack) else $error("preempted mid operation");

  property p_nan;
    cmd_wr && op == fcp_pkg::OP_ADD && (not_finite(st_reg.top) || not_finite(st_reg.sec))
      |=> st_reg.err;
  endproperty
  a_nan: assert property (p_nan) else $error("special input kept error clear");

  property p_chk;
    cmd_wr && op == fcp_pkg::OP_CHK && st_reg.err |=> main_error_set ##1 !main_error_set;
  endproperty
  a_chk: assert property (p_chk) else $error("error not propagated");

  property p_sw;
    sched_switch |=> st_reg.top == '0 && st_reg.thd == '0;
  endproperty
  a_sw: assert property (p_sw) else $error("stack kept over switch");

  property p_irq;
    irq |-> |(ist_reg & imsk_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without source");

  c_mul: cover property (cmd_wr && op == fcp_pkg::OP_MUL ##[1:40] fsm_reg == ST_IDLE);
  c_sq: cover property (sq_reg == 2'h3 ##[1:60] cmd_wr && sel == fcp_pkg::SEL_SQL);
  c_pre: cover property ($rose(preempt_ack) ##[1:50] $fell(preempt_ack));
  c_stl: cover property ((psel && penable && !pready) [*3] ##1 pready);
endmodule // fcp_top

// [include/fcp_pkg.sv]
// Shared constants and types of the floating point coprocessor port
package fcp_pkg;
  // APB register byte offsets
  localparam logic [7:0] ADDR_CMD  = 8'h00;
  localparam logic [7:0] ADDR_DLO  = 8'h04;
  localparam logic [7:0] ADDR_DHI  = 8'h08;
  localparam logic [7:0] ADDR_RLO  = 8'h0C;
  localparam logic [7:0] ADDR_RHI  = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [7:0] ADDR_IST  = 8'h18;
  localparam logic [7:0] ADDR_IMSK = 8'h1C;
  // Command fields
  localparam int CMD_DBL = 16;
  // Operation codes
  localparam logic [7:0] OP_LDS   = 8'h8E;
  localparam logic [7:0] OP_LDD   = 8'h8A;
  localparam logic [7:0] OP_STS   = 8'h88;
  localparam logic [7:0] OP_STD   = 8'h84;
  localparam logic [7:0] OP_ADD   = 8'h87;
  localparam logic [7:0] OP_SUB   = 8'h89;
  localparam logic [7:0] OP_MUL   = 8'h8B;
  localparam logic [7:0] OP_DIV   = 8'h8C;
  localparam logic [7:0] OP_ENTRY = 8'hAB;
  localparam logic [7:0] OP_REV   = 8'hA4;
  localparam logic [7:0] OP_DUP   = 8'hA3;
  localparam logic [7:0] OP_CHK   = 8'h83;
  localparam logic [7:0] OP_TEST  = 8'h9C;
  // Entry selectors
  localparam logic [7:0] SEL_ABS   = 8'h0B;
  localparam logic [7:0] SEL_RN    = 8'h22;
  localparam logic [7:0] SEL_RZ    = 8'h06;
  localparam logic [7:0] SEL_RP    = 8'h04;
  localparam logic [7:0] SEL_RM    = 8'h05;
  localparam logic [7:0] SEL_SETE  = 8'h23;
  localparam logic [7:0] SEL_CLRE  = 8'h9C;
  localparam logic [7:0] SEL_MUL2  = 8'h12;
  localparam logic [7:0] SEL_DIV2  = 8'h11;
  localparam logic [7:0] SEL_SQ1   = 8'h01;
  localparam logic [7:0] SEL_SQS   = 8'h02;
  localparam logic [7:0] SEL_SQL   = 8'h03;
  // Busy cycles per operation
  localparam logic [5:0] LAT_ONE  = 6'h01;
  localparam logic [5:0] LAT_ABS  = 6'h02;
  localparam logic [5:0] LAT_ADD  = 6'h06;
  localparam logic [5:0] LAT_MUL  = 6'h12;
  localparam logic [5:0] LAT_DIV  = 6'h1F;
  localparam logic [5:0] LAT_SQ1  = 6'h1B;
  localparam logic [5:0] LAT_SQS  = 6'h2A;
  localparam logic [5:0] LAT_SQL  = 6'h08;
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR  = 1;
  localparam int IRQ_SAVE = 2;
  typedef enum logic [1:0] {RND_NEAR, RND_ZERO, RND_POS, RND_MINUS} fcp_rnd_t;
  typedef struct packed {
    logic        dbl;
    logic [63:0] val;
  } fcp_entry_t;
  typedef struct packed {
    fcp_entry_t top;
    fcp_entry_t sec;
    fcp_entry_t thd;
    logic       err;
    fcp_rnd_t   rnd;
  } fcp_state_t;
endpackage

// [dv/fcp_core_model.sv]
// Core-side model: APB master and scheduling signals
`timescale 1ns/1ps
module fcp_core_model (
  // Clock
  input  wire logic        sys_clk,
  // APB master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  // Scheduling
  output logic             sched_switch,
  output logic             preempt_req,
  output logic             resume_req
);
  int unsigned wait_cycles;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    sched_switch = 1'b0;
    preempt_req = 1'b0;
    resume_req = 1'b0;
  end
  // Operands and results only move through the data registers
  // The core stalls on pready for as long as the unit needs
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge sys_clk);
    penable <= 1'b1;
    wait_cycles = 0;
    do begin
      @(posedge sys_clk);
      wait_cycles++;
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines do not keep their last value
    paddr <= ~addr;
    pwdata <= ~wdata;
  endtask
  // One-cycle scheduling pulses
  task automatic pulse(input logic sw, input logic rs);
    @(posedge sys_clk);
    sched_switch <= sw;
    resume_req <= rs;
    @(posedge sys_clk);
    sched_switch <= 1'b0;
    resume_req <= 1'b0;
  endtask
  task automatic set_preempt(input logic v);
    @(posedge sys_clk);
    preempt_req <= v;
  endtask
endmodule // fcp_core_model

// [dv/fcp_top_bench.sv]
// Self-checking bench of the floating point coprocessor port
`timescale 1ns/1ps
module fcp_top_bench;
  logic        sys_clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        sched_switch;
  logic        preempt_req;
  logic        resume_req;
  logic        preempt_ack;
  logic        main_error_set;
  logic        irq;
  logic [31:0] rv;
  logic        re;
  int          n_errors = 0;
  int          compares = 0;
  int          n_mes = 0;

  fcp_top dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sched_switch(sched_switch), .preempt_req(preempt_req), .resume_req(resume_req),
    .preempt_ack(preempt_ack), .main_error_set(main_error_set), .irq(irq));
  fcp_core_model core_u (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sched_switch(sched_switch), .preempt_req(preempt_req), .resume_req(resume_req));

  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (main_error_set === 1'b1) n_mes <= n_mes + 1;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    core_u.xfer(1'b1, addr, data, rv, re);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] sel);
    wr(fcp_pkg::ADDR_CMD, {16'h0000, sel, op});
  endtask
  task automatic rd_chk(input string name, input logic [7:0] addr, input logic [31:0] mask,
                        input logic [31:0] exp);
    core_u.xfer(1'b0, addr, 32'h0000_0000, rv, re);
    check(name, rv & mask, exp);
  endtask
  // Polls busy; a long operation may take over forty cycles
  task automatic idle();
    do begin
      core_u.xfer(1'b0, fcp_pkg::ADDR_STAT, 32'h0000_0000, rv, re);
    end while (rv[6] !== 1'b0);
  endtask
  task automatic load_s(input logic [31:0] v);
    wr(fcp_pkg::ADDR_DLO, v);
    cmd(fcp_pkg::OP_LDS, 8'h00);
  endtask
  task automatic t_reset();
    check("irq", {31'h0, irq}, 32'h0000_0000);
    rd_chk("stat", fcp_pkg::ADDR_STAT, 32'h0000_03FF, 32'h0000_0000);
    rd_chk("imsk", fcp_pkg::ADDR_IMSK, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk("ist", fcp_pkg::ADDR_IST, 32'hFFFF_FFFF, 32'h0000_0000);
  endtask
  task automatic t_refuse();
    logic [7:0] bad [3] = '{8'h20, 8'h02, 8'hFC};
    foreach (bad[i]) begin
      core_u.xfer(i[0], bad[i], 32'hFFFF_FFFF, rv, re);
      check("slverr", {31'h0, re}, 32'h0000_0001);
      check("rdata", rv, 32'h0000_0000);
    end
  endtask
  task automatic t_stack();
    load_s(32'h3F80_0000);
    wr(fcp_pkg::ADDR_DLO, 32'h1122_3344);
    wr(fcp_pkg::ADDR_DHI, 32'h5566_7788);
    cmd(fcp_pkg::OP_LDD, 8'h00);
    rd_chk("tags", fcp_pkg::ADDR_STAT, 32'h0000_000E, 32'h0000_0002);
    cmd(fcp_pkg::OP_STD, 8'h00);
    rd_chk("rlo", fcp_pkg::ADDR_RLO, 32'hFFFF_FFFF, 32'h1122_3344);
    rd_chk("rhi", fcp_pkg::ADDR_RHI, 32'hFFFF_FFFF, 32'h5566_7788);
    rd_chk("tags", fcp_pkg::ADDR_STAT, 32'h0000_000E, 32'h0000_0000);
    cmd(fcp_pkg::OP_STS, 8'h00);
    rd_chk("rlo", fcp_pkg::ADDR_RLO, 32'hFFFF_FFFF, 32'h3F80_0000);
  endtask
  task automatic t_round();
    logic [7:0] sel [4] = '{fcp_pkg::SEL_RZ, fcp_pkg::SEL_RP, fcp_pkg::SEL_RM, fcp_pkg::SEL_RN};
    foreach (sel[i]) begin
      cmd(fcp_pkg::OP_ENTRY, sel[i]);
      rd_chk("rnd", fcp_pkg::ADDR_STAT, 32'h0000_0030, ((i + 1) % 4) << 4);
    end
  endtask
  task automatic t_err();
    logic [31:0] bad [2] = '{32'h7FC0_0000, 32'h7F80_0000};
    int m;
    m = n_mes;
    cmd(fcp_pkg::OP_ENTRY, fcp_pkg::SEL_SETE);
    rd_chk("err", fcp_pkg::ADDR_STAT, 32'h0000_0001, 32'h0000_0001);
    check("main", n_mes - m, 32'h0000_0000);
    cmd(fcp_pkg::OP_CHK, 8'h00);
    idle();
    check("main", n_mes - m, 32'h0000_0001);
    cmd(fcp_pkg::OP_TEST, 8'h00);
    idle();
    rd_chk("test", fcp_pkg::ADDR_RLO, 32'h0000_0001, 32'h0000_0000);
    rd_chk("err", fcp_pkg::ADDR_STAT, 32'h0000_0001, 32'h0000_0000);
    cmd(fcp_pkg::OP_TEST, 8'h00);
    idle();
    rd_chk("test", fcp_pkg::ADDR_RLO, 32'h0000_0001, 32'h0000_0001);
    load_s(32'h0000_0000);
    load_s(32'h0000_0000);
    cmd(fcp_pkg::OP_DIV, 8'h00);
    idle();
    rd_chk("err", fcp_pkg::ADDR_STAT, 32'h0000_0001, 32'h0000_0001);
    cmd(fcp_pkg::OP_ENTRY, fcp_pkg::SEL_CLRE);
    rd_chk("err", fcp_pkg::ADDR_STAT, 32'h0000_0001, 32'h0000_0000);
    foreach (bad[i]) begin
      load_s(bad[i]);
      load_s(32'h3F80_0000);
      cmd(i ? fcp_pkg::OP_MUL : fcp_pkg::OP_ADD, 8'h00);
      idle();
      rd_chk("err", fcp_pkg::ADDR_STAT, 32'h0000_0001, 32'h0000_0001);
      cmd(fcp_pkg::OP_ENTRY, fcp_pkg::SEL_CLRE);
    end
  endtask
  task automatic t_abs_sqrt();
    logic [7:0] seq [4] = '{fcp_pkg::SEL_SQ1, fcp_pkg::SEL_SQS, fcp_pkg::SEL_SQS, fcp_pkg::SEL_SQL};
    // Operand and expected result: one doubled, smallest normal halved into a denormal
    logic [63:0] sc [2] = '{64'h3F80_0000_4000_0000, 64'h0080_0000_0040_0000};
    foreach (sc[i]) begin
      load_s(sc[i][63:32]);
      cmd(fcp_pkg::OP_ENTRY, i ? fcp_pkg::SEL_DIV2 : fcp_pkg::SEL_MUL2);
      cmd(fcp_pkg::OP_STS, 8'h00);
      rd_chk("scale", fcp_pkg::ADDR_RLO, 32'hFFFF_FFFF, sc[i][31:0]);
    end
    load_s(32'hBF80_0000);
    cmd(fcp_pkg::OP_ENTRY, fcp_pkg::SEL_ABS);
    cmd(fcp_pkg::OP_STS, 8'h00);
    rd_chk("abs", fcp_pkg::ADDR_RLO, 32'hFFFF_FFFF, 32'h3F80_0000);
    load_s(32'h4080_0000);
    foreach (seq[i]) begin
      cmd(fcp_pkg::OP_ENTRY, seq[i]);
      idle();
    end
    rd_chk("err", fcp_pkg::ADDR_STAT, 32'h0000_0001, 32'h0000_0000);
    cmd(fcp_pkg::OP_ENTRY, fcp_pkg::SEL_SQS);
    idle();
    rd_chk("err", fcp_pkg::ADDR_STAT, 32'h0000_0001, 32'h0000_0001);
    cmd(fcp_pkg::OP_ENTRY, fcp_pkg::SEL_CLRE);
  endtask
  task automatic t_switch_stall();
    wr(fcp_pkg::ADDR_DHI, 32'h4000_0000);
    cmd(fcp_pkg::OP_LDD, 8'h00);
    core_u.pulse(1'b1, 1'b0);
    rd_chk("tags", fcp_pkg::ADDR_STAT, 32'h0000_000E, 32'h0000_0000);
    cmd(fcp_pkg::OP_STD, 8'h00);
    rd_chk("rhi", fcp_pkg::ADDR_RHI, 32'hFFFF_FFFF, 32'h0000_0000);
    cmd(fcp_pkg::OP_DIV, 8'h00);
    cmd(fcp_pkg::OP_DUP, 8'h00);
    check("stall", {31'h0, core_u.wait_cycles >= 20}, 32'h0000_0001);
    idle();
    cmd(fcp_pkg::OP_ENTRY, fcp_pkg::SEL_CLRE);
  endtask
  task automatic t_irq();
    wr(fcp_pkg::ADDR_IST, 32'h0000_0007);
    wr(fcp_pkg::ADDR_IMSK, 32'h0000_0001);
    cmd(fcp_pkg::OP_DUP, 8'h00);
    idle();
    check("irq", {31'h0, irq}, 32'h0000_0001);
    wr(fcp_pkg::ADDR_IST, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    check("irq", {31'h0, irq}, 32'h0000_0000);
    cmd(fcp_pkg::OP_DUP, 8'h00);
    wr(fcp_pkg::ADDR_IMSK, 32'h0000_0000);
    repeat (2) @(posedge sys_clk);
    check("irq", {31'h0, irq}, 32'h0000_0000);
    rd_chk("ist", fcp_pkg::ADDR_IST, 32'h0000_0001, 32'h0000_0001);
  endtask
  task automatic t_preempt();
    int n;
    cmd(fcp_pkg::OP_ENTRY, fcp_pkg::SEL_SETE);
    cmd(fcp_pkg::OP_ENTRY, fcp_pkg::SEL_RZ);
    wr(fcp_pkg::ADDR_IST, 32'h0000_0007);
    load_s(32'h3F80_0000);
    load_s(32'h3F80_0000);
    cmd(fcp_pkg::OP_MUL, 8'h00);
    rd_chk("busy", fcp_pkg::ADDR_STAT, 32'h0000_0040, 32'h0000_0040);
    core_u.set_preempt(1'b1);
    repeat (2) @(posedge sys_clk);
    check("ack", {31'h0, preempt_ack}, 32'h0000_0000);
    n = 0;
    while (preempt_ack !== 1'b1 && n < 60) begin
      @(posedge sys_clk);
      n++;
    end
    check("ack", {31'h0, preempt_ack}, 32'h0000_0001);
    rd_chk("saved", fcp_pkg::ADDR_STAT, 32'h0000_0031, 32'h0000_0000);
    rd_chk("ist", fcp_pkg::ADDR_IST, 32'h0000_0004, 32'h0000_0004);
    load_s(32'hAAAA_5555);
    cmd(fcp_pkg::OP_STS, 8'h00);
    rd_chk("rlo", fcp_pkg::ADDR_RLO, 32'hFFFF_FFFF, 32'hAAAA_5555);
    cmd(fcp_pkg::OP_ENTRY, fcp_pkg::SEL_RP);
    rd_chk("rnd", fcp_pkg::ADDR_STAT, 32'h0000_0030, 32'h0000_0020);
    core_u.set_preempt(1'b0);
    core_u.pulse(1'b0, 1'b1);
    repeat (2) @(posedge sys_clk);
    check("ack", {31'h0, preempt_ack}, 32'h0000_0000);
    rd_chk("back", fcp_pkg::ADDR_STAT, 32'h0000_0031, 32'h0000_0011);
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_refuse();
    t_stack();
    t_round();
    t_err();
    t_abs_sqrt();
    t_switch_stall();
    t_irq();
    t_preempt();
    final_report();
  end
  // Whole run is under a thousand cycles; this span of 30000 cycles leaves wide margin
  initial begin
    #(40 * 30000);
    n_errors++;
    final_report();
  end
endmodule // fcp_top_bench
